/* File: pkg/fap_pkg.sv */
// Constants, field layouts and state types of the auto poller.
// Assumes one 100 MHz system clock and AXI4-Lite register access.
// How it works
// - identify success sets status bit 0
// - tag read success sets bit 1
// - sensor read success sets bit 2
// - output info success sets bit 3
// - data poll success sets bit 4
// - float region at record bytes 60..99
// - damping float bytes 96..99 from output info
// - records stay inside 3000 database words
// - disabled mode runs only user commands
// - point-to-point polls address zero only
// - point-to-point repeats data poll once found
// - point-to-point interleaves config reads occasionally
// - point-to-point identifies again, less often
// - point-to-point lost link retries identify
// - point-to-point user command after data poll
// - multi-drop polls 1 up to maximum
// - multi-drop never polls above maximum
// - at most 15 devices, addressed from 1
// - config for next found device, rotating
// - identify unfound addresses now and then
// - all devices lost, search with identify
// - multi-drop user commands after full pass
// - each device owns fifty record words
package fap_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00; // Mode, max address, enable
	localparam logic [7:0] REG_BASE = 8'h04; // Record area base word
	localparam logic [7:0] REG_USER = 8'h08; // User command and go
	localparam logic [7:0] REG_UDB = 8'h0C; // User result base word
	localparam logic [7:0] REG_STAT = 8'h10; // Poller state, read only
	localparam int CTRL_MAX_LSB = 4; // Max address field
	localparam int CTRL_UEN_BIT = 8; // User command enable
	localparam int USER_ADR_LSB = 8; // User target address
	localparam int USER_GO_BIT = 31; // Request pending
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Modes, commands, status bits
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_P2P = 2'h1,
		MODE_MULTI = 2'h2} fap_mode_e;
	localparam logic [7:0] CMD_IDENT = 8'h00;
	localparam logic [7:0] CMD_DATA = 8'h03;
	localparam logic [7:0] CMD_TAG = 8'h0D;
	localparam logic [7:0] CMD_SENS = 8'h0E;
	localparam logic [7:0] CMD_OUT = 8'h0F;
	localparam int SB_IDENT = 0;
	localparam int SB_TAG = 1;
	localparam int SB_SENS = 2;
	localparam int SB_OUT = 3;
	localparam int SB_DATA = 4;
	// ----------------------------------------------------------------
	// Record layout and database size
	// ----------------------------------------------------------------
	localparam logic [13:0] REC_WORDS = 14'h0032; // Fifty words
	localparam logic [13:0] DB_BYTES = 14'h1770; // 3000 words
	localparam logic [3:0] MAX_ADDR = 4'hF; // Fifteen devices
	localparam logic [6:0] OF_ID_LO = 7'h03; // Identify 3..18
	localparam logic [6:0] OF_ID_HI = 7'h12;
	localparam logic [6:0] OF_UN_LO = 7'h13; // Units 19..22
	localparam logic [6:0] OF_UN_HI = 7'h16;
	localparam logic [6:0] OF_TG_LO = 7'h17; // Tag 23..49
	localparam logic [6:0] OF_TG_HI = 7'h31;
	localparam logic [6:0] OF_SN_LO = 7'h32; // Sensor 50..53
	localparam logic [6:0] OF_SN_HI = 7'h35;
	localparam logic [6:0] OF_OI_LO = 7'h36; // Output info 54..59
	localparam logic [6:0] OF_OI_HI = 7'h3B;
	localparam logic [6:0] OF_PV_LO = 7'h3C; // Variables 60..75
	localparam logic [6:0] OF_PV_HI = 7'h4B;
	localparam logic [6:0] OF_TL_LO = 7'h4C; // Limits, span 76..87
	localparam logic [6:0] OF_TL_HI = 7'h57;
	localparam logic [6:0] OF_RV_LO = 7'h58; // Range, damping 88..99
	localparam logic [6:0] OF_RV_HI = 7'h63;
	localparam logic [6:0] OF_DAMP_LO = 7'h60; // Damping 96..99
	// ----------------------------------------------------------------
	// Pacing counts (poll passes) and state types
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_EVERY = 8'h08;
	localparam logic [7:0] ID_EVERY = 8'h20;
	typedef enum logic [2:0] {S_IDLE = 3'h0, S_PICK = 3'h1,
		S_REQ = 3'h3, S_WAIT = 3'h2, S_STAT = 3'h6} fap_state_e;
	typedef enum logic [1:0] {T_POLL = 2'h0, T_USER = 2'h1,
		T_CFG = 2'h3, T_ID = 2'h2} fap_tail_e;
endpackage : fap_pkg

/* File: rtl/fap_poller.sv */
// Auto poll sequencer for one instrument loop channel.
// Assumes a transaction engine on the CMD/DONE/RSP ports and a
// byte-wide database write port; registers over AXI4-Lite.
module fap_poller import fap_pkg::*; (
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	output logic [1:0] S_AXI_BRESP_OUT,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	input wire logic [7:0] S_AXI_ARADDR_IN,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic CMD_VALID_OUT,
	input wire logic CMD_READY_IN,
	output logic [7:0] CMD_CODE_OUT,
	output logic [3:0] CMD_ADDR_OUT,
	output logic CMD_USER_OUT,
	input wire logic DONE_VALID_IN,
	input wire logic DONE_OK_IN,
	input wire logic RSP_VALID_IN,
	input wire logic [6:0] RSP_OFS_IN,
	input wire logic [7:0] RSP_BYTE_IN,
	output logic DB_WE_OUT,
	output logic [12:0] DB_ADDR_OUT,
	output logic [7:0] DB_DATA_OUT
);
	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Record byte address of a device, addresses 0 and 1 sharing the first record
	function automatic logic [13:0] rec_ba(input logic [11:0] b,
		input logic [3:0] a);
		logic [13:0] w;
		w = 14'(b) + 14'((a == 4'h0) ? 4'h0 : a - 4'h1) * REC_WORDS;
		return {w[12:0], 1'b0};
	endfunction : rec_ba
	// Response bytes a command may place into the record
	function automatic logic ofs_ok(input logic [7:0] c,
		input logic [6:0] o);
		case (c)
			CMD_IDENT: ofs_ok = o >= OF_ID_LO && o <= OF_ID_HI;
			CMD_DATA: ofs_ok = (o >= OF_UN_LO && o <= OF_UN_HI) ||
				(o >= OF_PV_LO && o <= OF_PV_HI);
			CMD_TAG: ofs_ok = o >= OF_TG_LO && o <= OF_TG_HI;
			CMD_SENS: ofs_ok = (o >= OF_SN_LO && o <= OF_SN_HI) ||
				(o >= OF_TL_LO && o <= OF_TL_HI);
			CMD_OUT: ofs_ok = (o >= OF_OI_LO && o <= OF_OI_HI) ||
				(o >= OF_RV_LO && o <= OF_RV_HI);
			default: ofs_ok = 1'b0;
		endcase
	endfunction : ofs_ok
	// Status bit of a command, bit 3 of result flags "has one"
	function automatic logic [3:0] cmd_bit(input logic [7:0] c);
		case (c)
			CMD_IDENT: cmd_bit = {1'b1, 3'(SB_IDENT)};
			CMD_TAG: cmd_bit = {1'b1, 3'(SB_TAG)};
			CMD_SENS: cmd_bit = {1'b1, 3'(SB_SENS)};
			CMD_OUT: cmd_bit = {1'b1, 3'(SB_OUT)};
			CMD_DATA: cmd_bit = {1'b1, 3'(SB_DATA)};
			default: cmd_bit = 4'h0;
		endcase
	endfunction : cmd_bit
	// Write data merged under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (nw & m);
	endfunction : merge
	// Next found address after cur, wrapping to lowest found
	function automatic logic [3:0] next_found(input logic [15:0] f,
		input logic [3:0] cur, input logic [3:0] mx);
		logic [3:0] lo;
		logic [3:0] hi;
		logic up;
		lo = cur;
		hi = cur;
		up = 1'b0;
		for (int k = 15; k >= 1; k--) begin
			if (4'(k) <= mx && f[k]) begin
				lo = 4'(k);
				if (4'(k) > cur) begin
					hi = 4'(k);
					up = 1'b1;
				end
			end
		end
		return up ? hi : lo;
	endfunction : next_found

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_q1; // First stage, read only by second
	logic rst_n; // Synchronised reset, active low
	// Asynchronous assert, two-stage release
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	fap_mode_e mode; // Poll mode
	logic [3:0] maxa; // Highest multi-drop address
	logic uen; // User commands enabled
	logic [11:0] rec_base; // record_area_base, word index
	logic [7:0] ucmd; // User command code
	logic [3:0] uaddr; // User target address
	logic user_go; // User command pending
	logic [11:0] udb; // User result base word
	logic aw_ok; // Write address held
	logic [7:0] aw_a;
	logic w_ok; // Write data held
	logic [31:0] w_d;
	logic [3:0] w_s;
	logic [15:0] found; // Devices answering identify
	logic searched; // Initial search done
	fap_tail_e tail;
	fap_state_e state;
	logic issue;
	logic p_user;
	// Register images as software sees them
	wire [31:0] ctrl_img = {23'h0, uen, maxa, 2'h0, mode};
	wire [31:0] user_img = {user_go, 19'h0, uaddr, ucmd};
	wire [31:0] stat_img = {10'h0, tail, searched, state, found};
	wire do_wr = aw_ok && w_ok && !S_AXI_BVALID_OUT;
	wire wr_ctrl = do_wr && aw_a == REG_CTRL;
	wire wr_base = do_wr && aw_a == REG_BASE;
	wire wr_user = do_wr && aw_a == REG_USER;
	wire wr_udb = do_wr && aw_a == REG_UDB;
	wire wr_hit = wr_ctrl || wr_base || wr_user || wr_udb;
	wire [31:0] m_ctrl = merge(ctrl_img, w_d, w_s);
	wire [31:0] m_base = merge({20'h0, rec_base}, w_d, w_s);
	wire [31:0] m_user = merge(user_img, w_d, w_s);
	wire [31:0] m_udb = merge({20'h0, udb}, w_d, w_s);
	wire [1:0] m_mode = m_ctrl[1:0];
	wire ar_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	wire [7:0] ra = S_AXI_ARADDR_IN;
	wire rd_hit = ra == REG_CTRL || ra == REG_BASE || ra == REG_USER ||
		ra == REG_UDB || ra == REG_STAT;
	wire [31:0] rd_mux = (ra == REG_CTRL) ? ctrl_img :
		(ra == REG_BASE) ? {20'h0, rec_base} :
		(ra == REG_USER) ? user_img :
		(ra == REG_UDB) ? {20'h0, udb} :
		(ra == REG_STAT) ? stat_img : 32'h0000_0000;
	// Address and data may arrive in either order
	assign S_AXI_AWREADY_OUT = !aw_ok && !S_AXI_BVALID_OUT;
	assign S_AXI_WREADY_OUT = !w_ok && !S_AXI_BVALID_OUT;
	assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
	// Channel capture and responses
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			aw_ok <= 1'b0;
			aw_a <= 8'h00;
			w_ok <= 1'b0;
			w_d <= 32'h0000_0000;
			w_s <= 4'h0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= RESP_OKAY;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h0000_0000;
			S_AXI_RRESP_OUT <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_ok <= 1'b1;
				aw_a <= S_AXI_AWADDR_IN;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_ok <= 1'b1;
				w_d <= S_AXI_WDATA_IN;
				w_s <= S_AXI_WSTRB_IN;
			end
			// Read-only and unmapped words answer with an error
			if (do_wr) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
			if (ar_take) begin
				S_AXI_RVALID_OUT <= 1'b1;
				S_AXI_RDATA_OUT <= rd_mux;
				S_AXI_RRESP_OUT <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RREADY_IN) begin
				S_AXI_RVALID_OUT <= 1'b0;
			end
		end
	end
	// Configuration registers; software go beats hardware clear
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			mode <= MODE_OFF;
			maxa <= 4'h0;
			uen <= 1'b0;
			rec_base <= 12'h000;
			ucmd <= 8'h00;
			uaddr <= 4'h0;
			user_go <= 1'b0;
			udb <= 12'h000;
		end else begin
			if (state == S_PICK && issue && p_user) begin
				user_go <= 1'b0;
			end
			if (wr_ctrl) begin
				// Unknown mode code falls back to disabled
				mode <= (m_mode == MODE_P2P || m_mode == MODE_MULTI) ?
					fap_mode_e'(m_mode) : MODE_OFF;
				maxa <= m_ctrl[CTRL_MAX_LSB +: 4];
				uen <= m_ctrl[CTRL_UEN_BIT];
			end
			if (wr_base) begin
				rec_base <= m_base[11:0];
			end
			if (wr_user) begin
				ucmd <= m_user[7:0];
				uaddr <= m_user[USER_ADR_LSB +: 4];
				if (m_user[USER_GO_BIT]) begin
					user_go <= 1'b1;
				end
			end
			if (wr_udb) begin
				udb <= m_udb[11:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Poll scheduler
	// ----------------------------------------------------------------
	logic [3:0] scan; // Multi-drop pass position
	logic [1:0] cfg_step; // 0 tag, 1 sensor, 2 output
	logic [3:0] cfg_dev; // Device owed a config read
	logic [3:0] probe; // Next unfound address to try
	logic [7:0] cfg_cnt; // Passes until next config read
	logic [7:0] id_cnt; // Passes until next identify
	logic [7:0] p_cmd;
	logic [3:0] p_addr;
	logic [3:0] next_scan;
	logic [1:0] next_step;
	logic [3:0] next_cdev;
	logic [3:0] next_probe;
	logic [7:0] next_ccnt;
	logic [7:0] next_icnt;
	logic next_srch;
	fap_tail_e next_tail;
	wire is_p2p = mode == MODE_P2P;
	wire is_multi = mode == MODE_MULTI;
	wire ugo = user_go && uen;
	wire last = scan >= maxa;
	wire [3:0] cdev = is_p2p ? 4'h0 : cfg_dev;
	wire cdev_ok = found[cdev] && (is_p2p || cdev <= maxa);
	wire probe_ok = probe != 4'h0 && probe <= maxa && !found[probe];
	wire [3:0] nf = next_found(found, cfg_dev, maxa);
	wire [7:0] cfg_code = (cfg_step == 2'h0) ? CMD_TAG :
		(cfg_step == 2'h1) ? CMD_SENS : CMD_OUT;
	// Choose the next command; a pass may step without issuing
	always_comb begin
		issue = 1'b0;
		p_user = 1'b0;
		p_cmd = CMD_DATA;
		p_addr = 4'h0;
		next_scan = scan;
		next_tail = tail;
		next_srch = searched;
		next_step = cfg_step;
		next_cdev = cfg_dev;
		next_probe = probe;
		next_ccnt = cfg_cnt;
		next_icnt = id_cnt;
		if (state == S_PICK && mode == MODE_OFF) begin
			issue = ugo;
			p_user = 1'b1;
		end else if (state == S_PICK) begin
			case (tail)
				T_POLL: begin
					if (is_p2p) begin
						// Address zero only; identify until it answers
						issue = 1'b1;
						p_cmd = found[0] ? CMD_DATA : CMD_IDENT;
						next_tail = found[0] ? T_USER : T_POLL;
					end else begin
						// Ascending sweep, identify while searching
						// Found bits above a lowered maximum stay unpolled
						issue = (searched ? found[scan] : 1'b1) && scan <= maxa;
						p_cmd = searched ? CMD_DATA : CMD_IDENT;
						p_addr = scan;
						next_scan = last ? 4'h1 : scan + 4'h1;
						next_srch = searched || last;
						next_tail = (searched && last) ? T_USER : T_POLL;
					end
				end
				T_USER: begin
					// User work only once the data pass is over
					issue = ugo;
					p_user = 1'b1;
					next_tail = T_CFG;
				end
				T_CFG: begin
					if (cfg_cnt != 8'h00) begin
						next_ccnt = cfg_cnt - 8'h01;
						next_tail = T_ID;
					end else begin
						issue = cdev_ok;
						p_cmd = cfg_code;
						p_addr = cdev;
						next_step = cfg_step + 2'h1;
						if (cfg_step == 2'h2 || !cdev_ok) begin
							next_step = 2'h0;
							next_cdev = nf;
							next_ccnt = CFG_EVERY - 8'h01;
							next_tail = T_ID;
						end
					end
				end
				T_ID: begin
					next_tail = T_POLL;
					if (id_cnt != 8'h00) begin
						next_icnt = id_cnt - 8'h01;
					end else begin
						issue = is_p2p || probe_ok;
						p_cmd = CMD_IDENT;
						p_addr = is_p2p ? 4'h0 : probe;
						next_icnt = ID_EVERY - 8'h01;
						next_probe = (probe >= maxa || probe >= MAX_ADDR) ?
							4'h1 : probe + 4'h1;
					end
					// Every device gone: start a fresh search
					// Address zero left over from point-to-point is ignored
					if (is_multi && found[15:1] == 15'h0000) begin
						next_srch = 1'b0;
					end
				end
				default: next_tail = T_POLL;
			endcase
		end
	end
	// Scheduler state
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			scan <= 4'h1;
			tail <= T_POLL;
			searched <= 1'b0;
			cfg_step <= 2'h0;
			cfg_dev <= 4'h1;
			probe <= 4'h1;
			cfg_cnt <= CFG_EVERY - 8'h01;
			id_cnt <= ID_EVERY - 8'h01;
		end else begin
			scan <= next_scan;
			tail <= next_tail;
			searched <= next_srch;
			cfg_step <= next_step;
			cfg_dev <= next_cdev;
			probe <= next_probe;
			cfg_cnt <= next_ccnt;
			id_cnt <= next_icnt;
		end
	end

	// ----------------------------------------------------------------
	// Transaction sequencer
	// ----------------------------------------------------------------
	logic [4:0] sbits [16]; // Command status bits per address
	wire done_ev = state == S_WAIT && DONE_VALID_IN;
	wire [3:0] cb = cmd_bit(CMD_CODE_OUT);
	assign CMD_VALID_OUT = state == S_REQ;
	// One command in flight; status byte written after each non-user command whose record starts inside the database
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			CMD_CODE_OUT <= 8'h00;
			CMD_ADDR_OUT <= 4'h0;
			CMD_USER_OUT <= 1'b0;
		end else begin
			case (state)
				S_IDLE: state <= S_PICK;
				S_PICK: begin
					if (issue) begin
						CMD_CODE_OUT <= p_user ? ucmd : p_cmd;
						CMD_ADDR_OUT <= p_user ? uaddr : p_addr;
						CMD_USER_OUT <= p_user;
						state <= S_REQ;
					end
				end
				S_REQ: state <= CMD_READY_IN ? S_WAIT : S_REQ;
				S_WAIT: begin
					if (DONE_VALID_IN) begin
						state <= CMD_USER_OUT ? S_PICK : S_STAT;
					end
				end
				S_STAT: state <= S_PICK;
				default: state <= S_IDLE;
			endcase
		end
	end
	// Outcome tracking; failure never leaves a stale success
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			found <= 16'h0000;
			for (int i = 0; i < 16; i++) begin
				sbits[i] <= 5'h00;
			end
		end else if (done_ev && !CMD_USER_OUT) begin
			if (cb[3]) begin
				sbits[CMD_ADDR_OUT][cb[2:0]] <= DONE_OK_IN;
			end
			if (CMD_CODE_OUT == CMD_IDENT) begin
				found[CMD_ADDR_OUT] <= DONE_OK_IN;
			end else if (CMD_CODE_OUT == CMD_DATA && !DONE_OK_IN) begin
				found[CMD_ADDR_OUT] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Database write port
	// ----------------------------------------------------------------
	wire [13:0] rec = rec_ba(rec_base, CMD_ADDR_OUT);
	wire [13:0] rsp_ba = (CMD_USER_OUT ? {1'b0, udb, 1'b0} : rec) +
		14'(RSP_OFS_IN);
	wire rsp_ev = state == S_WAIT && RSP_VALID_IN;
	// Each command only fills its own fields of the record
	wire rsp_take = rsp_ev && rsp_ba < DB_BYTES &&
		(CMD_USER_OUT || ofs_ok(CMD_CODE_OUT, RSP_OFS_IN));
	wire stat_ev = state == S_STAT && rec < DB_BYTES;
	wire next_db_we = rsp_take || stat_ev;
	wire [13:0] next_db_addr = stat_ev ? rec : rsp_ba;
	wire [7:0] next_db_data = stat_ev ? {3'h0, sbits[CMD_ADDR_OUT]} :
		RSP_BYTE_IN;
	// Registered write strobe, address and byte
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			DB_WE_OUT <= 1'b0;
			DB_ADDR_OUT <= 13'h0000;
			DB_DATA_OUT <= 8'h00;
		end else begin
			DB_WE_OUT <= next_db_we;
			DB_ADDR_OUT <= next_db_addr[12:0];
			DB_DATA_OUT <= next_db_data;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	wire ok_done = done_ev && DONE_OK_IN && !CMD_USER_OUT && rec < DB_BYTES;
	a_ident_bit: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		ok_done && CMD_CODE_OUT == CMD_IDENT |=> state == S_STAT
		##1 DB_WE_OUT && DB_DATA_OUT[SB_IDENT])
		else $error("identify success not recorded");
	a_data_bit: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		ok_done && CMD_CODE_OUT == CMD_DATA |-> ##2 DB_WE_OUT &&
		DB_DATA_OUT[SB_DATA] && DB_DATA_OUT[7:5] == 3'h0)
		else $error("data poll success not recorded");
	a_fail_clear: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		done_ev && !DONE_OK_IN && !CMD_USER_OUT && cb[3] &&
		rec < DB_BYTES |-> ##2 DB_WE_OUT && !DB_DATA_OUT[$past(cb[2:0], 2)])
		else $error("failed command left status bit");
	a_p2p_addr: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		state == S_PICK && issue && !p_user && is_p2p |=>
		CMD_VALID_OUT && CMD_ADDR_OUT == 4'h0)
		else $error("point-to-point polled nonzero address");
	a_multi_range: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		state == S_PICK && issue && !p_user && is_multi |=>
		CMD_ADDR_OUT >= 4'h1 && CMD_ADDR_OUT <= $past(maxa))
		else $error("multi-drop address out of range");
	a_off_user: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		state == S_PICK && mode == MODE_OFF |=>
		state == S_PICK || (CMD_VALID_OUT && CMD_USER_OUT))
		else $error("auto command in disabled mode");
	a_float_win: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		rsp_ev && !CMD_USER_OUT && CMD_CODE_OUT == CMD_DATA &&
		RSP_OFS_IN >= OF_PV_LO && RSP_OFS_IN <= OF_PV_HI &&
		rsp_ba < DB_BYTES |=> DB_WE_OUT &&
		DB_DATA_OUT == $past(RSP_BYTE_IN) &&
		DB_ADDR_OUT == $past(rsp_ba[12:0]))
		else $error("process value not stored");
	a_damp_src: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		rsp_ev && !CMD_USER_OUT && CMD_CODE_OUT != CMD_OUT &&
		RSP_OFS_IN >= OF_DAMP_LO && RSP_OFS_IN <= OF_RV_HI |=> !DB_WE_OUT)
		else $error("damping written by wrong command");
	a_db_limit: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		DB_WE_OUT |-> 14'(DB_ADDR_OUT) < DB_BYTES)
		else $error("write beyond database");
endmodule : fap_poller

/* File: sim/fap_inst_model.sv */
// Loop model: takes one command, sends one record byte, then done.
// Assumes commands are held until taken; absent address fails.
module fap_inst_model import fap_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [15:0] here_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [3:0] cmd_addr_in,
	output logic cmd_ready_out,
	output logic done_valid_out,
	output logic done_ok_out,
	output logic rsp_valid_out,
	output logic [6:0] rsp_ofs_out,
	output logic [7:0] rsp_byte_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] step; // Answer phase, 0 idle
	logic [7:0] code;
	logic [3:0] adr;
	// Only listed addresses answer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			step <= 3'h0;
			code <= 8'h00;
			adr <= 4'h0;
		end else if (step != 3'h0) begin
			step <= step + 3'h1;
		end else if (cmd_valid_in) begin
			step <= 3'h1;
			code <= cmd_code_in;
			adr <= cmd_addr_in;
		end
	end
	assign cmd_ready_out = (step == 3'h0);
	assign rsp_valid_out = (step == 3'h4) & here_in[adr];
	assign done_valid_out = (step == 3'h6);
	assign done_ok_out = here_in[adr];
	assign rsp_ofs_out = (code == CMD_OUT) ? 7'h60 :
		(code == CMD_DATA) ? 7'h3C : 7'h03;
	// Idle byte lines keep changing so stale data never passes
	assign rsp_byte_out = rsp_valid_out ? {4'h5, adr} : {step, 5'h15};
endmodule : fap_inst_model

/* File: sim/tb_fap_poller.sv */
// Bench: register set-up, command order and record writes.
// Assumes fap_inst_model answers on the command link.
module tb_fap_poller import fap_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, d;
	logic [1:0] r;
	logic [15:0] here = 0; // Instruments present
	wire aw_r, w_r, bv, ar_r, rv, cv, cr, cu, dv, dok, rsv, we;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [7:0] cc, rb, dd;
	wire [3:0] ca;
	wire [6:0] ro;
	wire [12:0] da;
	logic [12:0] cq[$]; // Commands taken
	logic [20:0] dq[$]; // Record writes
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
`define CMP(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
	always #5 clk = ~clk;
	fap_poller i_fap_poller (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(aw_r),
		.S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(w_r),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_BVALID_OUT(bv),
		.S_AXI_BREADY_IN(bre), .S_AXI_BRESP_OUT(br), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(ar_r), .S_AXI_ARADDR_IN(ara),
		.S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre), .S_AXI_RDATA_OUT(rdat),
		.S_AXI_RRESP_OUT(rr), .CMD_VALID_OUT(cv), .CMD_READY_IN(cr),
		.CMD_CODE_OUT(cc), .CMD_ADDR_OUT(ca), .CMD_USER_OUT(cu),
		.DONE_VALID_IN(dv), .DONE_OK_IN(dok), .RSP_VALID_IN(rsv),
		.RSP_OFS_IN(ro), .RSP_BYTE_IN(rb), .DB_WE_OUT(we), .DB_ADDR_OUT(da),
		.DB_DATA_OUT(dd));
	fap_inst_model i_fap_inst_model (.clk_in(clk), .rst_n_in(rst_n),
		.here_in(here), .cmd_valid_in(cv), .cmd_code_in(cc),
		.cmd_addr_in(ca), .cmd_ready_out(cr), .done_valid_out(dv),
		.done_ok_out(dok), .rsp_valid_out(rsv), .rsp_ofs_out(ro),
		.rsp_byte_out(rb));
	// Monitor off the edge, so handshakes are seen settled
	always @(negedge clk) begin
		if (cv & cr) cq.push_back({cu, cc, ca});
		if (we) dq.push_back({da, dd});
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	function automatic logic [7:0] last(input logic [12:0] a);
		logic [7:0] v;
		v = 8'hxx;
		foreach (dq[i]) if (dq[i][20:8] == a) v = dq[i][7:0];
		return v;
	endfunction : last
	task rst;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		cq.delete();
		dq.delete();
	endtask : rst
	task wq(input int n);
		while (cq.size() < n) @(posedge clk);
	endtask : wq
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw;
		@(posedge clk);
		awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= v; bre <= 1'b1;
		do begin
			@(negedge clk);
			ta = aw_r & awv;
			tw = w_r & wv;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while ((awv & !ta) | (wv & !tw));
		do @(negedge clk); while (!bv);
		r = br;
		@(posedge clk);
		bre <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk);
		arv <= 1'b1; ara <= a; rre <= 1'b1;
		do @(negedge clk); while (!ar_r);
		@(posedge clk);
		arv <= 1'b0;
		do @(negedge clk); while (!rv);
		d = rdat;
		r = rr;
		@(posedge clk);
		rre <= 1'b0;
	endtask : rd
	task sc_user;
		rst();
		wr(REG_CTRL, 32'h0000_0100);
		`CMP("ctrl resp", RESP_OKAY, r)
		wr(REG_USER, 32'h8000_0122);
		wq(1);
		`CMP("user", {1'b1, 8'h22, 4'h1}, cq[0])
		rd(REG_USER);
		`CMP("go cleared", 32'h0000_0122, d)
		rd(REG_CTRL);
		`CMP("ctrl back", 32'h0000_0100, d)
		wr(REG_STAT, 32'h0000_0000);
		`CMP("ro write", RESP_SLVERR, r)
		rd(8'h14);
		`CMP("unmapped", RESP_SLVERR, r)
		`CMP("unmapped data", 32'h0000_0000, d)
	endtask : sc_user
	task sc_p2p;
		rst();
		here <= 16'h0001;
		wr(REG_BASE, 32'h0000_0064);
		wr(REG_CTRL, 32'h0000_0001);
		wq(2);
		`CMP("first", {1'b0, CMD_IDENT, 4'h0}, cq[0])
		`CMP("second", {1'b0, CMD_DATA, 4'h0}, cq[1])
		while (cq[$][11:4] != CMD_OUT) @(posedge clk);
		`CMP("cfg", {CMD_TAG, CMD_SENS}, {cq[$-2][11:4], cq[$-1][11:4]})
		wq(cq.size() + 1);
		`CMP("damping", 8'h50, last(13'h0128))
		`CMP("status", 8'h1F, last(13'h00C8))
		here <= 16'h0000;
		cq.delete();
		wq(6);
		`CMP("retry", {1'b0, CMD_IDENT, 4'h0}, cq[5])
		`CMP("cleared", 8'h00, last(13'h00C8) & 8'h11)
	endtask : sc_p2p
	task sc_multi;
		rst();
		// Address 5 sits above the maximum and must stay silent
		here <= 16'h0026;
		wr(REG_BASE, 32'h0000_0064);
		wr(REG_CTRL, 32'h0000_0032);
		wq(12);
		for (int i = 0; i < 3; i++)
			`CMP("search", {1'b0, CMD_IDENT, 4'(i + 1)}, cq[i])
		`CMP("pass", {1'b0, CMD_DATA, 4'h2}, cq[4])
		foreach (cq[i]) `CMP("max", 1'b1, cq[i][3:0] < 4'h4)
		`CMP("rec two", 8'h11, last(13'h012C) & 8'h11)
	endtask : sc_multi
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		sc_user();
		sc_p2p();
		sc_multi();
		end_of_test();
	end
endmodule : tb_fap_poller
